// File: hw/emc_params.svh
// Constants for the exception mask and thread control register block.
`ifndef EMC_PARAMS_SVH
`define EMC_PARAMS_SVH

// Special-register select codes on the move port.
`define EMC_SEL_PRI 2'h0
`define EMC_SEL_FAULT 2'h1
`define EMC_SEL_BASE 2'h2
`define EMC_SEL_CTRL 2'h3

// Field positions.
`define EMC_MASK_BIT 0
`define EMC_BASE_HI 7
`define EMC_BASE_LO 4
`define EMC_CTRL_STACK_BIT 1
`define EMC_CTRL_PRIV_BIT 0

// Reset values.
`define EMC_RST_MASK 1'h0
`define EMC_RST_BASE 4'h0
`define EMC_RST_CTRL 1'h0

`endif

// File: hw/emc_pkg.sv
// Types shared by the exception mask and thread control register block.
`default_nettype none
`include "emc_params.svh"
package emc_pkg;

	// Execution mode of the core, one-hot.
	typedef enum logic [1:0] {
		EMC_THREAD = 2'b01,
		EMC_HANDLER = 2'b10
	} emc_mode_t;

	// Special-register select.
	typedef logic [1:0] emc_sel_t;

	// Complete state of the register block.
	typedef struct packed {
		emc_mode_t mode;
		logic exception_priority_mask;
		logic fault_escalation_mask;
		logic [3:0] base_priority_field;
		logic stackSel;
		logic threadPriv;
		logic actAllowed;
		logic actValid;
		logic [31:0] rdData;
		logic rdValid;
		logic handlerMode;
		logic procStack;
	} emc_state_t;

endpackage : emc_pkg
`default_nettype wire

// File: hw/emc_mask_ctrl.sv
// Exception mask, base priority and thread control registers with the gate.
`timescale 1ns/1ps
`default_nettype none
`include "emc_params.svh"
module emc_mask_ctrl (
	input wire logic mclk,
	input wire logic rst_n,
	// Special-register move port.
	input wire logic srWrEn,
	input wire logic srRdEn,
	input wire emc_pkg::emc_sel_t srSel,
	input wire logic [31:0] srWrData,
	// Processor-state change port for the two mask bits.
	input wire logic maskChgEn,
	input wire logic maskChgSet,
	input wire logic maskChgPri,
	input wire logic maskChgFault,
	// Exception entry and return from the core sequencer.
	input wire logic excEntry,
	input wire logic excReturn,
	input wire logic retFromNmi,
	input wire logic retToThread,
	input wire logic retProcStack,
	// Activation query from the exception prioritiser.
	input wire logic reqValid,
	input wire logic reqIsNmi,
	input wire logic reqConfigurable,
	input wire logic [7:0] reqPriority,
	output logic actAllowed,
	output logic actValid,
	output logic [31:0] srRdData,
	output logic srRdValid,
	output logic priorityMaskOut,
	output logic faultMaskOut,
	output logic [7:0] basePriOut,
	output logic threadUnpriv,
	output logic handlerMode,
	output logic procStackActive
);
	import emc_pkg::*;

	emc_state_t st_reg;
	emc_state_t st_next;

	////////////////////////////////////////////////////////////////////////
	// Activation decision for one request against the current masks.
	function automatic logic emc_allowed(
		input emc_state_t s,
		input logic isNmi,
		input logic cfg,
		input logic [7:0] prio
	);
		logic ok;
		ok = 1'b1;
		if (s.fault_escalation_mask) begin
			ok = 1'b0;
		end
		if (cfg && s.exception_priority_mask) begin
			ok = 1'b0;
		end
		if (cfg && (s.base_priority_field != `EMC_RST_BASE) &&
		    (prio >= {s.base_priority_field, 4'h0})) begin
			ok = 1'b0;
		end
		// The non-maskable interrupt overrides every mask, so it is last.
		if (isNmi) begin
			ok = 1'b1;
		end
		return ok;
	endfunction : emc_allowed

	////////////////////////////////////////////////////////////////////////
	// Next-state logic for registers, mode and outputs.
	always_comb begin
		st_next = st_reg;
		st_next.actValid = reqValid;
		st_next.rdValid = srRdEn;
		// Reads see the value before any write in the same cycle.
		if (srRdEn) begin
			st_next.rdData = 32'h0;
			unique case (srSel)
				`EMC_SEL_PRI: st_next.rdData[`EMC_MASK_BIT] = st_reg.exception_priority_mask;
				`EMC_SEL_FAULT: st_next.rdData[`EMC_MASK_BIT] = st_reg.fault_escalation_mask;
				`EMC_SEL_BASE: begin
					st_next.rdData[`EMC_BASE_HI:`EMC_BASE_LO] = st_reg.base_priority_field;
				end
				`EMC_SEL_CTRL: begin
					st_next.rdData[`EMC_CTRL_STACK_BIT] =
					    st_reg.stackSel && (st_reg.mode == EMC_THREAD);
					st_next.rdData[`EMC_CTRL_PRIV_BIT] = st_reg.threadPriv;
				end
			endcase
		end
		// Exception return first, so a software write of the fault mask in the same cycle wins.
		if (excReturn) begin
			if (!retFromNmi) begin
				st_next.fault_escalation_mask = 1'b0;
			end
			if (retToThread) begin
				st_next.mode = EMC_THREAD;
				st_next.stackSel = retProcStack;
			end
		end
		// Entry for any exception other than reset goes to Handler mode.
		if (excEntry) begin
			st_next.mode = EMC_HANDLER;
			st_next.stackSel = 1'b0;
		end
		// Processor-state change touches only the two mask bits.
		if (maskChgEn) begin
			if (maskChgPri) begin
				st_next.exception_priority_mask = maskChgSet;
			end
			if (maskChgFault) begin
				st_next.fault_escalation_mask = maskChgSet;
			end
		end
		// Special-register writes; reserved bits are dropped.
		if (srWrEn) begin
			unique case (srSel)
				`EMC_SEL_PRI: st_next.exception_priority_mask = srWrData[`EMC_MASK_BIT];
				`EMC_SEL_FAULT: st_next.fault_escalation_mask = srWrData[`EMC_MASK_BIT];
				`EMC_SEL_BASE: begin
					st_next.base_priority_field = srWrData[`EMC_BASE_HI:`EMC_BASE_LO];
				end
				`EMC_SEL_CTRL: begin
					// An entry in this cycle already means Handler mode.
					if (st_reg.mode == EMC_THREAD && !excEntry) begin
						st_next.stackSel = srWrData[`EMC_CTRL_STACK_BIT];
					end
					st_next.threadPriv = srWrData[`EMC_CTRL_PRIV_BIT];
				end
			endcase
		end
		st_next.actAllowed =
		    emc_allowed(st_reg, reqIsNmi, reqConfigurable, reqPriority);
		st_next.handlerMode = (st_next.mode == EMC_HANDLER);
		st_next.procStack =
		    st_next.stackSel && (st_next.mode == EMC_THREAD);
	end

	////////////////////////////////////////////////////////////////////////
	// State register; reset clears every field except mode, which loads Thread.
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			st_reg <= '0;
			st_reg.mode <= EMC_THREAD;
			st_reg.exception_priority_mask <= `EMC_RST_MASK;
			st_reg.fault_escalation_mask <= `EMC_RST_MASK;
			st_reg.base_priority_field <= `EMC_RST_BASE;
			st_reg.stackSel <= `EMC_RST_CTRL;
			st_reg.threadPriv <= `EMC_RST_CTRL;
		end else begin
			st_reg <= st_next;
		end
	end

	// Outputs straight from the state register.
	assign actAllowed = st_reg.actAllowed;
	assign actValid = st_reg.actValid;
	assign srRdData = st_reg.rdData;
	assign srRdValid = st_reg.rdValid;
	assign priorityMaskOut = st_reg.exception_priority_mask;
	assign faultMaskOut = st_reg.fault_escalation_mask;
	assign basePriOut = {st_reg.base_priority_field, 4'h0};
	assign threadUnpriv = st_reg.threadPriv;
	assign handlerMode = st_reg.handlerMode;
	assign procStackActive = st_reg.procStack;

	////////////////////////////////////////////////////////////////////////
	// Checks on the design's own behaviour.
	pri_block_a: assert property (@(posedge mclk) disable iff (!rst_n)
	    (reqValid && reqConfigurable && !reqIsNmi && priorityMaskOut)
	    |=> (actValid && !actAllowed))
	    else $error("Priority mask let a configurable exception through.");

	fault_block_a: assert property (@(posedge mclk) disable iff (!rst_n)
	    (reqValid && !reqIsNmi && faultMaskOut) |=> !actAllowed)
	    else $error("Fault mask let a non-NMI exception through.");

	nmi_pass_a: assert property (@(posedge mclk) disable iff (!rst_n)
	    (reqValid && reqIsNmi) |=> (actValid && actAllowed))
	    else $error("NMI was blocked.");

	fault_clear_a: assert property (@(posedge mclk) disable iff (!rst_n)
	    (excReturn && !retFromNmi && !srWrEn && !maskChgEn) |=> !faultMaskOut)
	    else $error("Fault mask not cleared on handler exit.");

	base_block_a: assert property (@(posedge mclk) disable iff (!rst_n)
	    (reqValid && reqConfigurable && !reqIsNmi && basePriOut != 8'h00 &&
	     reqPriority >= basePriOut) |=> !actAllowed)
	    else $error("Base priority did not block a lower priority.");

	open_pass_a: assert property (@(posedge mclk) disable iff (!rst_n)
	    (reqValid && !faultMaskOut && !priorityMaskOut && basePriOut == 8'h00)
	    |=> actAllowed)
	    else $error("Exception blocked with all masks clear.");

	handler_stack_a: assert property (@(posedge mclk) disable iff (!rst_n)
	    handlerMode |-> !procStackActive)
	    else $error("Process stack in use in Handler mode.");

	ctrl_read_a: assert property (@(posedge mclk) disable iff (!rst_n)
	    (srRdEn && srSel == `EMC_SEL_CTRL && handlerMode)
	    |=> (srRdValid && !srRdData[`EMC_CTRL_STACK_BIT]))
	    else $error("Stack select read as one in Handler mode.");

	entry_mode_a: assert property (@(posedge mclk) disable iff (!rst_n)
	    excEntry |=> (handlerMode && !procStackActive) [*1])
	    else $error("Exception entry did not reach Handler mode.");

	stack_write_a: assert property (@(posedge mclk) disable iff (!rst_n)
	    (srWrEn && srSel == `EMC_SEL_CTRL && !handlerMode && !excEntry &&
	     !excReturn)
	    |=> (procStackActive == $past(srWrData[`EMC_CTRL_STACK_BIT])))
	    else $error("Thread stack select write not taken.");

	priv_write_a: assert property (@(posedge mclk) disable iff (!rst_n)
	    (srWrEn && srSel == `EMC_SEL_CTRL)
	    |=> (threadUnpriv == $past(srWrData[`EMC_CTRL_PRIV_BIT])))
	    else $error("Thread privilege write not taken.");

endmodule : emc_mask_ctrl
`default_nettype wire

// File: verification/emc_mask_ctrl_tb.sv
// Self-checking bench for the exception mask and thread control registers.
`timescale 1ns/1ps
`default_nettype none
`include "emc_params.svh"
`define CHK(a, e) \
	begin \
		nChecks++; \
		if ((a) !== (e)) begin \
			mismatches++; \
			$display("Error at %0t: got %h, expected %h", $time, a, e); \
		end \
	end
module emc_mask_ctrl_tb;
	import emc_pkg::*;
	logic mclk = 1'h0, rst_n = 1'h0, srWrEn = 1'h0, srRdEn = 1'h0;
	emc_sel_t srSel = 2'h0;
	logic [31:0] srWrData = 32'h0;
	logic maskChgEn = 1'h0, maskChgSet = 1'h0;
	logic maskChgPri = 1'h0, maskChgFault = 1'h0;
	logic excEntry = 1'h0, excReturn = 1'h0, retFromNmi = 1'h0;
	logic retToThread = 1'h0, retProcStack = 1'h0, reqValid = 1'h0;
	logic reqIsNmi = 1'h0, reqConfigurable = 1'h0;
	logic [7:0] reqPriority = 8'h0;
	logic actAllowed, actValid, srRdValid, priorityMaskOut, faultMaskOut;
	logic threadUnpriv, handlerMode, procStackActive;
	logic [31:0] srRdData;
	logic [7:0] basePriOut;
	int mismatches = 0, nChecks = 0;

	emc_mask_ctrl u_dut (.mclk, .rst_n, .srWrEn, .srRdEn, .srSel, .srWrData,
		.maskChgEn, .maskChgSet, .maskChgPri, .maskChgFault, .excEntry,
		.excReturn, .retFromNmi, .retToThread, .retProcStack, .reqValid,
		.reqIsNmi, .reqConfigurable, .reqPriority, .actAllowed, .actValid,
		.srRdData, .srRdValid, .priorityMaskOut, .faultMaskOut, .basePriOut,
		.threadUnpriv, .handlerMode, .procStackActive);

	// Free-running 50 MHz clock.
	always #10 mclk = ~mclk;

	////////////////////////////////////////////////////////////////////////
	// Steps one edge and lands just after it.
	task automatic tick;
		@(posedge mclk);
		#1;
	endtask : tick
	// Prints the counts and the verdict, then stops.
	task automatic tallyAndFinish;
		$display("Checks %0d, mismatches %0d", nChecks, mismatches);
		if (mismatches == 0 && nChecks > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : tallyAndFinish
	// Special-register write, one strobe cycle then one idle cycle.
	task automatic wr(input emc_sel_t s, input logic [31:0] d);
		srWrEn = 1'h1;
		srSel = s;
		srWrData = d;
		tick();
		srWrEn = 1'h0;
		tick();
	endtask : wr
	// Special-register read; the answer stands one cycle after the strobe.
	task automatic rd(input emc_sel_t s, input logic [31:0] exp);
		srRdEn = 1'h1;
		srSel = s;
		tick();
		srRdEn = 1'h0;
		`CHK(srRdValid, 1'h1)
		`CHK(srRdData, exp)
		tick();
	endtask : rd
	// Activation query with the expected verdict.
	task automatic q(input logic nmi, cfg, input logic [7:0] p, input logic e);
		reqValid = 1'h1;
		reqIsNmi = nmi;
		reqConfigurable = cfg;
		reqPriority = p;
		tick();
		reqValid = 1'h0;
		`CHK(actValid, 1'h1)
		`CHK(actAllowed, e)
		tick();
	endtask : q
	// State change of the mask bits.
	task automatic maskChg(input logic v, pri, flt);
		maskChgEn = 1'h1;
		maskChgSet = v;
		maskChgPri = pri;
		maskChgFault = flt;
		tick();
		maskChgEn = 1'h0;
		tick();
	endtask : maskChg
	// Exception event: {entry, return, from NMI, to Thread, process stack}.
	task automatic exc(input logic [4:0] f);
		{excEntry, excReturn, retFromNmi, retToThread, retProcStack} = f;
		tick();
		excEntry = 1'h0;
		excReturn = 1'h0;
		tick();
	endtask : exc

	////////////////////////////////////////////////////////////////////////
	// Main sequence.
	initial begin
		repeat (10) tick();
		rst_n = 1'h1;
		`CHK(handlerMode, 1'h0)
		`CHK(procStackActive, 1'h0)
		rd(`EMC_SEL_PRI, 32'h0);
		rd(`EMC_SEL_FAULT, 32'h0);
		rd(`EMC_SEL_BASE, 32'h0);
		rd(`EMC_SEL_CTRL, 32'h0);
		q(1'h0, 1'h1, 8'hFF, 1'h1);
		wr(`EMC_SEL_PRI, 32'hFFFFFFFF);
		`CHK(priorityMaskOut, 1'h1)
		rd(`EMC_SEL_PRI, 32'h1);
		q(1'h0, 1'h1, 8'h00, 1'h0);
		q(1'h0, 1'h0, 8'h00, 1'h1);
		maskChg(1'h0, 1'h1, 1'h0);
		q(1'h0, 1'h1, 8'h00, 1'h1);
		maskChg(1'h1, 1'h0, 1'h1);
		rd(`EMC_SEL_FAULT, 32'h1);
		q(1'h0, 1'h0, 8'h00, 1'h0);
		q(1'h1, 1'h0, 8'h00, 1'h1);
		exc(5'h10);
		`CHK(handlerMode, 1'h1)
		exc(5'h0C);
		`CHK(faultMaskOut, 1'h1)
		exc(5'h08);
		`CHK(faultMaskOut, 1'h0)
		wr(`EMC_SEL_BASE, 32'hFFFFFF3F);
		rd(`EMC_SEL_BASE, 32'h30);
		`CHK(basePriOut, 8'h30)
		q(1'h0, 1'h1, 8'h30, 1'h0);
		q(1'h0, 1'h1, 8'h2F, 1'h1);
		wr(`EMC_SEL_BASE, 32'h0);
		q(1'h0, 1'h1, 8'hFF, 1'h1);
		wr(`EMC_SEL_CTRL, 32'h3);
		rd(`EMC_SEL_CTRL, 32'h1);
		`CHK(procStackActive, 1'h0)
		`CHK(threadUnpriv, 1'h1)
		exc(5'h0B);
		`CHK(procStackActive, 1'h1)
		rd(`EMC_SEL_CTRL, 32'h3);
		exc(5'h10);
		`CHK(procStackActive, 1'h0)
		exc(5'h0A);
		// A quiet cycle after the stack write stands in for the barrier.
		wr(`EMC_SEL_CTRL, 32'hFFFFFFFE);
		tick();
		rd(`EMC_SEL_CTRL, 32'h2);
		`CHK(procStackActive, 1'h1)
		`CHK(threadUnpriv, 1'h0)
		// Load every field, then pull reset in mid-run and see all clear.
		wr(`EMC_SEL_CTRL, 32'h3);
		`CHK(procStackActive, 1'h1)
		maskChg(1'h1, 1'h1, 1'h1);
		wr(`EMC_SEL_BASE, 32'hF0);
		`CHK(priorityMaskOut, 1'h1)
		`CHK(faultMaskOut, 1'h1)
		`CHK(basePriOut, 8'hF0)
		`CHK(threadUnpriv, 1'h1)
		rst_n = 1'h0;
		repeat (2) tick();
		rst_n = 1'h1;
		`CHK(priorityMaskOut, 1'h0)
		`CHK(faultMaskOut, 1'h0)
		`CHK(basePriOut, 8'h00)
		`CHK(threadUnpriv, 1'h0)
		`CHK(procStackActive, 1'h0)
		`CHK(handlerMode, 1'h0)
		rd(`EMC_SEL_CTRL, 32'h0);
		rd(`EMC_SEL_FAULT, 32'h0);
		q(1'h0, 1'h1, 8'hFF, 1'h1);
		tallyAndFinish();
	end

	// Cuts a hung run short and counts it as a mismatch.
	initial begin
		repeat (5000) @(posedge mclk);
		$display("Error at %0t: run timed out", $time);
		mismatches++;
		tallyAndFinish();
	end
endmodule : emc_mask_ctrl_tb
`default_nettype wire
